// [hw/boot_config_word_decode.v]
`timescale 1ns/1ns
`include "boot_config_word_decode_regs.vh"

// How it works
// - Code protect bit 28 low blocks external programmer flash access.
// - Boot guard bit 24 low refuses boot flash writes during execution.
// - Master clear pin gives system reset when bit 23 high, else power-on.
// - Field 19:12 is ones complement of guarded page count; all ones none.
// - Each step down guards another 4 KB page; codes below BF reserved.
// - Channel field codes 11,10,01,00 pick debug pin pairs one to four.
// - Bit 2 enables scan port and is copied into control register at load.
// - Debugger on while field bit 1 low; protection forces field to 11.
// - Identity is 4-bit revision over 28-bit identifier, both read-only.
// - Unimplemented bits read zero and ignore writes.
// - Control register resets to 000B with scan and test output set.
// - Offsets 4, 8 and C clear, set and toggle written one bits.
module boot_config_word_decode #(
  parameter [3:0] SILICON_REV = 4'h0,     // Arbitrary value.
  parameter [27:0] DEVICE_CODE = 28'h0000000 // Arbitrary value.
) (
  input wire clk_sys_i,
  input wire rstn_i,
  // APB slave.
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [15:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output wire pslverr_o,
  output reg [31:0] prdata_o,
  // Nonvolatile memory read of the configuration word.
  output wire nvm_req_o,
  input wire nvm_ack_i,
  input wire [31:0] nvm_data_i,
  output wire load_done_o,
  // External programmer access gate.
  input wire prog_access_req_i,
  output wire prog_access_grant_o,
  output wire code_protect_en_o,
  // Boot and program flash write gates for code execution.
  input wire boot_wr_req_i,
  output wire boot_wr_allow_o,
  input wire pgm_wr_req_i,
  input wire [17:0] pgm_wr_addr_i,
  output wire pgm_wr_allow_o,
  output wire [6:0] pgm_guard_pages_o,
  // Master clear pin and the resets it produces.
  input wire master_clear_pin_n_i,
  output reg sys_reset_req_o,
  output reg por_req_o,
  // Debug and scan controls.
  output wire [3:0] debug_pin_pair_o,
  output wire debugger_en_o,
  output wire scan_port_enable_o,
  output wire test_out_enable_o,
  output wire pin_remap_lock_o,
  output wire module_disable_lock_o,
  input wire remap_fault_i,
  output wire cfg_reserved_err_o
);

  // ===========================================================
  // Functions.

  // Next value of a register for a plain, clear, set or invert write.
  // Code 0 is the plain write; 1, 2 and 3 are clear, set and invert.
  function [31:0] alias_apply;
    input [31:0] old_val;
    input [31:0] wdata;
    input [1:0] op;
    begin
      case (op)
        `ALIAS_CLR: alias_apply = old_val & ~wdata;
        `ALIAS_SET: alias_apply = old_val | wdata;
        `ALIAS_INV: alias_apply = old_val ^ wdata;
        default: alias_apply = wdata;
      endcase
    end
  endfunction

  // Number of guarded pages from the write guard code, capped at 64.
  function [6:0] guard_pages;
    input [7:0] code;
    reg [7:0] cnt;
    begin
      cnt = ~code;
      if (code < `PGM_GUARD_MIN) begin
        guard_pages = `PGM_MAX_PAGES;
      end else begin
        guard_pages = cnt[6:0];
      end
    end
  endfunction

  // ===========================================================
  // Configuration word load sequence.
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_REQ = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;

  reg [1:0] load_st_ff;
  reg [1:0] nxt_load_st;
  reg [31:0] boot_word_ff;

  // The load walks from idle to request to done once per reset.
  // A second load needs a new reset; late acknowledges are ignored.
  always @* begin
    nxt_load_st = load_st_ff;
    case (load_st_ff)
      ST_IDLE: nxt_load_st = ST_REQ;
      ST_REQ: begin
        if (nvm_ack_i) begin
          nxt_load_st = ST_DONE;
        end
      end
      ST_DONE: nxt_load_st = ST_DONE;
      default: nxt_load_st = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      load_st_ff <= ST_IDLE;
    end else begin
      load_st_ff <= nxt_load_st;
    end
  end

  // The word is captured once; software has no write path to it.
  // Until then it reads as all ones, the state of an erased word.
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_word_ff <= 32'hFFFFFFFF;
    end else if (load_st_ff == ST_REQ && nvm_ack_i) begin
      boot_word_ff <= nvm_data_i;
    end
  end

  wire loaded = (load_st_ff == ST_DONE);
  wire load_hit = (load_st_ff == ST_REQ) && nvm_ack_i;
  assign nvm_req_o = (load_st_ff == ST_REQ);
  assign load_done_o = loaded;

  // ===========================================================
  // Decode of the configuration word.

  // Protection is active low in the word; until loaded, act protected.
  // The registered copy lags the load by one cycle and stays set
  // through it, so a programmer is never granted early.
  wire cp_en = ~boot_word_ff[`BW_CODE_PROTECT_BIT] | ~loaded;
  reg cp_en_ff;
  assign code_protect_en_o = cp_en_ff;
  assign prog_access_grant_o = prog_access_req_i & ~cp_en_ff;

  // Boot flash writes pass only while the guard bit is one.
  assign boot_wr_allow_o = boot_wr_req_i & loaded &
                           boot_word_ff[`BW_BOOT_GUARD_BIT];

  // Program flash pages below the guard count are refused. Before the
  // load every page counts as guarded, so the registered count never
  // shows a stale zero in the cycle in which the word arrives.
  wire [6:0] pages = loaded ? guard_pages(
    boot_word_ff[`BW_PGM_GUARD_HI:`BW_PGM_GUARD_LO]) :
    `PGM_MAX_PAGES;
  reg [6:0] pages_ff;
  wire [5:0] wr_page = pgm_wr_addr_i[`PGM_ADDR_W-1:`PGM_PAGE_LSB];
  wire page_guarded = ({1'b0, wr_page} < pages_ff);
  assign pgm_guard_pages_o = pages_ff;
  assign pgm_wr_allow_o = pgm_wr_req_i & loaded & ~page_guarded;

  // One-hot pin pair: code 11 is pair one, code 00 is pair four.
  wire [1:0] chan = boot_word_ff[`BW_CHAN_HI:`BW_CHAN_LO];
  wire [1:0] pair_idx = ~chan;
  wire [3:0] pair_dec = 4'h1 << pair_idx;
  reg [3:0] pair_ff;
  assign debug_pin_pair_o = pair_ff;

  // Code protection overrides the debugger field to disabled.
  wire [1:0] dbg_field = cp_en ? `BW_DEBUG_FORCED :
                         boot_word_ff[`BW_DEBUG_HI:`BW_DEBUG_LO];
  reg dbg_en_ff;
  assign debugger_en_o = dbg_en_ff;

  // Reserved positions that a programmer left at zero are flagged.
  // The flag only reports; decoding goes on with the word as read.
  wire rsv_err = loaded &
    ((boot_word_ff & `BW_RESERVED_MASK) != `BW_RESERVED_MASK);
  reg rsv_err_ff;
  assign cfg_reserved_err_o = rsv_err_ff;

  // Status outputs come from flops. Reset values are the most
  // restrictive ones: protected, every page guarded, debugger off.
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cp_en_ff <= 1'b1;
      pages_ff <= `PGM_MAX_PAGES;
      pair_ff <= 4'h1;
      dbg_en_ff <= 1'b0;
      rsv_err_ff <= 1'b0;
    end else begin
      cp_en_ff <= cp_en;
      pages_ff <= pages;
      pair_ff <= pair_dec;
      dbg_en_ff <= ~dbg_field[1];
      rsv_err_ff <= rsv_err;
    end
  end

  // ===========================================================
  // Master clear pin: three-stage synchroniser and reset choice.
  reg [2:0] master_clear_pin_sync_ff;
  reg master_clear_pin_state_ff;

  // Stage 0 may settle late; only stage 1 ever reads it.
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      master_clear_pin_sync_ff <= 3'h7;
    end else begin
      master_clear_pin_sync_ff <= {master_clear_pin_sync_ff[1:0], master_clear_pin_n_i};
    end
  end

  // A change counts only when the second and third stages agree.
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      master_clear_pin_state_ff <= 1'b1;
    end else if (master_clear_pin_sync_ff[1] == master_clear_pin_sync_ff[2]) begin
      master_clear_pin_state_ff <= master_clear_pin_sync_ff[2];
    end
  end

  // The filtered level falls: the pin has been pressed.
  wire master_clear_pin_fall = master_clear_pin_state_ff & (master_clear_pin_sync_ff[1] == master_clear_pin_sync_ff[2]) &
                   ~master_clear_pin_sync_ff[2];

  // One-cycle pulse of the reset kind that the soft clear bit selects.
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sys_reset_req_o <= 1'b0;
      por_req_o <= 1'b0;
    end else begin
      sys_reset_req_o <= master_clear_pin_fall &
                         boot_word_ff[`BW_SOFT_CLEAR_BIT];
      por_req_o <= master_clear_pin_fall & ~boot_word_ff[`BW_SOFT_CLEAR_BIT];
    end
  end

  // ===========================================================
  // APB register access.
  reg [31:0] cfg_ctrl_ff;
  reg [31:0] unlock_key_ff;

  wire [15:0] base = {paddr_i[15:4], 4'h0};
  wire [1:0] op = paddr_i[3:2];
  wire hit_cc = (base == `CFG_CONTROL_OFS);
  wire hit_key = (base == `UNLOCK_KEY_OFS);
  wire hit_id = (paddr_i == `DEV_IDENTITY_OFS);
  wire hit_bw = (paddr_i == `BOOT_WORD0_OFS);
  wire mapped = hit_cc | hit_key | hit_id | hit_bw;
  wire ro_hit = hit_id | hit_bw;
  wire aligned = (paddr_i[1:0] == 2'h0);
  wire access = psel_i & penable_i;
  // A refused write must leave the registers alone, so the alignment
  // that raises the error also gates the write strobes.
  wire wr_cc = access & pwrite_i & hit_cc & aligned;
  wire wr_key = access & pwrite_i & hit_key & aligned;

  // Zero wait states; unmapped or misaligned accesses and read-only
  // writes answer with an error.
  assign pready_o = 1'b1;
  assign pslverr_o = access & (~mapped | (pwrite_i & ro_hit) | ~aligned);

  // Control register, with the scan enable taken from the word at load.
  // Remap fault is set by hardware and wins over a software clear.
  wire [31:0] cc_written = alias_apply(cfg_ctrl_ff, pwdata_i, op);
  reg [31:0] nxt_cfg_ctrl;

  always @* begin
    nxt_cfg_ctrl = cfg_ctrl_ff;
    if (wr_cc) begin
      nxt_cfg_ctrl = cc_written & `CC_IMPL_MASK;
    end
    if (load_hit) begin
      // The loaded scan enable wins over a write in the same cycle.
      nxt_cfg_ctrl[`CC_SCAN_PORT_BIT] =
        nvm_data_i[`BW_SCAN_PORT_BIT];
    end
    if (remap_fault_i) begin
      nxt_cfg_ctrl[`CC_REMAP_FAULT_BIT] = 1'b1; // Set wins over clear.
    end
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_ctrl_ff <= `CC_RESET;
    end else begin
      cfg_ctrl_ff <= nxt_cfg_ctrl;
    end
  end

  // System key is a plain word with the same alias writes.
  // The key has no unlock sequence of its own here.
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      unlock_key_ff <= 32'h00000000;
    end else if (wr_key) begin
      unlock_key_ff <= alias_apply(unlock_key_ff, pwdata_i, op);
    end
  end

  assign scan_port_enable_o = cfg_ctrl_ff[`CC_SCAN_PORT_BIT];
  assign test_out_enable_o = cfg_ctrl_ff[`CC_TEST_OUT_BIT];
  assign pin_remap_lock_o = cfg_ctrl_ff[`CC_REMAP_LOCK_BIT];
  assign module_disable_lock_o = cfg_ctrl_ff[`CC_MODULE_LOCK_BIT];

  // Read data is captured in the setup cycle and held for the access.
  // A write leaves the last read data in place.
  reg [31:0] rd_mux;

  always @* begin
    // Unmapped addresses read zero.
    rd_mux = 32'h00000000;
    if (hit_cc) begin
      rd_mux = cfg_ctrl_ff;
    end else if (hit_key) begin
      rd_mux = unlock_key_ff;
    end else if (hit_id) begin
      rd_mux = {SILICON_REV, DEVICE_CODE};
    end else if (hit_bw) begin
      rd_mux = boot_word_ff;
    end
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_o <= rd_mux;
    end
  end

endmodule // boot_config_word_decode

// [shared/boot_config_word_decode_regs.vh]
`ifndef BOOT_CONFIG_WORD_DECODE_REGS_VH
`define BOOT_CONFIG_WORD_DECODE_REGS_VH

// =============================================================
// Register byte offsets within the system register group.
`define CFG_CONTROL_OFS 16'hF200
`define DEV_IDENTITY_OFS 16'hF220
`define UNLOCK_KEY_OFS 16'hF230
`define BOOT_WORD0_OFS 16'hF240

// Alias sub-offsets: plain write, clear, set, invert.
`define ALIAS_PLAIN 2'h0
`define ALIAS_CLR 2'h1
`define ALIAS_SET 2'h2
`define ALIAS_INV 2'h3

// =============================================================
// Configuration control fields and reset value.
`define CC_TEST_OUT_BIT 0
`define CC_SPARE_BIT 1
`define CC_SCAN_PORT_BIT 3
`define CC_REMAP_FAULT_BIT 8
`define CC_MODULE_LOCK_BIT 12
`define CC_REMAP_LOCK_BIT 13
`define CC_RESET 32'h0000000B
`define CC_IMPL_MASK 32'h0000310B

// =============================================================
// Boot configuration word 0 fields.
`define BW_CODE_PROTECT_BIT 28
`define BW_BOOT_GUARD_BIT 24
`define BW_SOFT_CLEAR_BIT 23
`define BW_PGM_GUARD_HI 19
`define BW_PGM_GUARD_LO 12
`define BW_CHAN_HI 4
`define BW_CHAN_LO 3
`define BW_SCAN_PORT_BIT 2
`define BW_DEBUG_HI 1
`define BW_DEBUG_LO 0
`define BW_RESERVED_MASK 32'hEE700FE0
`define BW_DEBUG_FORCED 2'h3

// =============================================================
// Program flash write guard geometry.
`define PGM_GUARD_NONE 8'hFF
`define PGM_GUARD_MIN 8'hBF
`define PGM_MAX_PAGES 7'h40
`define PGM_PAGE_LSB 12
`define PGM_ADDR_W 18

`endif

// [tb/boot_config_word_decode_monitor.sv]
`timescale 1ns/1ns
// =============================================================
// Port checker for the configuration word decoder.
module boot_config_word_decode_monitor (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [15:0] paddr_i,
  input wire pslverr_o,
  input wire nvm_req_o,
  input wire nvm_ack_i,
  input wire [31:0] nvm_data_i,
  input wire load_done_o,
  input wire prog_access_req_i,
  input wire prog_access_grant_o,
  input wire code_protect_en_o,
  input wire boot_wr_req_i,
  input wire boot_wr_allow_o,
  input wire pgm_wr_req_i,
  input wire [17:0] pgm_wr_addr_i,
  input wire pgm_wr_allow_o,
  input wire [6:0] pgm_guard_pages_o,
  input wire sys_reset_req_o,
  input wire por_req_o,
  input wire [3:0] debug_pin_pair_o,
  input wire debugger_en_o,
  input wire scan_port_enable_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  AST_GRANT: assert property (
    prog_access_grant_o == (prog_access_req_i && !code_protect_en_o))
    else $error("programmer grant wrong");
  AST_BOOT: assert property (
    boot_wr_allow_o |-> boot_wr_req_i && load_done_o)
    else $error("boot write allowed wrongly");
  AST_PGM: assert property (
    pgm_wr_allow_o == (pgm_wr_req_i && load_done_o &&
    pgm_wr_addr_i[17:12] >= pgm_guard_pages_o))
    else $error("program write gate wrong");
  AST_PAIR: assert property ($onehot(debug_pin_pair_o))
    else $error("pin pair not one-hot");
  AST_SCAN: assert property (
    nvm_req_o && nvm_ack_i |=> scan_port_enable_o == $past(nvm_data_i[2]))
    else $error("scan enable not loaded");
  AST_FORCE: assert property (code_protect_en_o |-> !debugger_en_o)
    else $error("debugger on under protection");
  AST_PULSE: assert property (
    sys_reset_req_o || por_req_o |=> !sys_reset_req_o && !por_req_o)
    else $error("reset pulse too long");
  AST_RO: assert property (
    psel_i && penable_i && pwrite_i && paddr_i == 16'hF220 |-> pslverr_o)
    else $error("identity write accepted");
  AST_LOAD: assert property (
    nvm_req_o && nvm_ack_i |=> load_done_o && !nvm_req_o)
    else $error("load did not complete");
  AST_HOLD: assert property (load_done_o |=> load_done_o)
    else $error("load done dropped");
endmodule // boot_config_word_decode_monitor

bind boot_config_word_decode boot_config_word_decode_monitor
  u_boot_config_word_decode_monitor (.*);

// [tb/nvm_word_model.sv]
`timescale 1ns/1ns
`include "boot_config_word_decode_regs.vh"
// =============================================================
// Memory holding the word a programmer wrote.
module nvm_word_model (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire req_i,
  input wire [31:0] word_i,
  input wire [3:0] delay_i,
  output wire ack_o,
  output wire [31:0] data_o
);
  reg ack_ff = 1'b0;
  reg [3:0] cnt_ff = 4'h0;
  // Answers a request after delay_i plus one idle cycles, for one cycle.
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_ff <= 1'b0;
      cnt_ff <= 4'h0;
    end else if (req_i && !ack_ff) begin
      if (cnt_ff == delay_i) ack_ff <= 1'b1;
      else cnt_ff <= cnt_ff + 4'h1;
    end else begin
      ack_ff <= 1'b0;
      cnt_ff <= 4'h0;
    end
  end
  // Reserved bits are written as ones; idle bus shows inverted data.
  assign data_o = ack_ff ? (word_i | `BW_RESERVED_MASK) : ~word_i;
  assign ack_o = ack_ff;
endmodule // nvm_word_model

// [tb/boot_config_word_decode_test.sv]
`timescale 1ns/1ns
// =============================================================
// Testbench for the configuration word decoder.
module boot_config_word_decode_test;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, prog_access_req_i = 1'b0, boot_wr_req_i = 1'b0;
  logic pgm_wr_req_i = 1'b0, master_clear_pin_n_i = 1'b1;
  logic remap_fault_i = 1'b0, err;
  logic [15:0] paddr_i = 16'h0000;
  logic [31:0] pwdata_i = 32'h00000000, word = 32'hFFFFFFFF, rd;
  logic [17:0] pgm_wr_addr_i = 18'h00000;
  logic [3:0] delay = 4'h0;
  logic pready_o, pslverr_o, nvm_req_o, nvm_ack_i, load_done_o;
  logic prog_access_grant_o, code_protect_en_o, boot_wr_allow_o;
  logic pgm_wr_allow_o, sys_reset_req_o, por_req_o, debugger_en_o;
  logic scan_port_enable_o, test_out_enable_o, pin_remap_lock_o;
  logic module_disable_lock_o, cfg_reserved_err_o;
  logic [31:0] prdata_o, nvm_data_i;
  logic [6:0] pgm_guard_pages_o;
  logic [3:0] debug_pin_pair_o;
  int n_fail = 0, samples_checked = 0;

  boot_config_word_decode u_boot_config_word_decode (.*);
  nvm_word_model u_nvm_word_model (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .req_i(nvm_req_o), .word_i(word), .delay_i(delay), .ack_o(nvm_ack_i),
    .data_o(nvm_data_i));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task results();
    $display("fails=%0d checks=%0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      results();
    end
  endtask

  task rchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask

  // Resets the block and lets the memory model supply a new word.
  task load_word(input logic [31:0] w, input logic [3:0] d);
    int n;
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    word <= w;
    delay <= d;
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    n = 0;
    while (load_done_o !== 1'b1 && n < 40) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 40) begin
      n_fail++;
      results();
    end
    #1;
  endtask

  // Drops the master clear pin and compares the reset pulses.
  task pin_pulse(input logic [1:0] exp);
    int n;
    @(posedge clk_sys_i);
    master_clear_pin_n_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (sys_reset_req_o !== 1'b1 && por_req_o !== 1'b1 && n < 12);
    check({sys_reset_req_o, por_req_o}, exp);
    @(posedge clk_sys_i);
    master_clear_pin_n_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    if (n >= 12) begin
      n_fail++;
      results();
    end
  endtask

  task t_open();
    load_word(32'hFFFFFFFF, 4'h0);
    check({code_protect_en_o, debugger_en_o}, 2'b00);
    check(pgm_guard_pages_o, 7'h00);
    check(debug_pin_pair_o, 4'h1);
    check(cfg_reserved_err_o, 1'b0);
    @(posedge clk_sys_i);
    prog_access_req_i <= 1'b1;
    boot_wr_req_i <= 1'b1;
    pgm_wr_req_i <= 1'b1;
    #1;
    check({prog_access_grant_o, boot_wr_allow_o}, 2'b11);
    check(pgm_wr_allow_o, 1'b1);
    pin_pulse(2'b10);
  endtask

  task t_regs();
    check({scan_port_enable_o, test_out_enable_o}, 2'h3);
    rchk(16'hF200, 32'h0000000B);
    rchk(16'hF220, 32'h00000000);
    apb(1'b1, 16'hF220, 32'hFFFFFFFF);
    check(err, 1'b1);
    rchk(16'hF240, 32'hFFFFFFFF);
    apb(1'b1, 16'hF240, 32'h00000000);
    check(err, 1'b1);
    apb(1'b1, 16'hF200, 32'hFFFFFEFF);
    rchk(16'hF200, 32'h0000300B);
    check({pin_remap_lock_o, module_disable_lock_o}, 2'h3);
    apb(1'b1, 16'hF204, 32'h00003000);
    rchk(16'hF200, 32'h0000000B);
    apb(1'b1, 16'hF208, 32'h00002000);
    rchk(16'hF200, 32'h0000200B);
    apb(1'b1, 16'hF20C, 32'h00002009);
    rchk(16'hF200, 32'h00000002);
    check({test_out_enable_o, scan_port_enable_o}, 2'h0);
    @(posedge clk_sys_i);
    remap_fault_i <= 1'b1;
    @(posedge clk_sys_i);
    remap_fault_i <= 1'b0;
    rchk(16'hF200, 32'h00000102);
    apb(1'b1, 16'hF209, 32'h00002000);
    check(err, 1'b1);
    rchk(16'hF200, 32'h00000102);
    apb(1'b1, 16'hF230, 32'hA5A5A5A5);
    apb(1'b1, 16'hF234, 32'hFFFF0000);
    rchk(16'hF230, 32'h0000A5A5);
    apb(1'b0, 16'hF210, 32'h00000000);
    check(err, 1'b1);
  endtask

  task t_protect();
    load_word(32'hEFFFEFE0, 4'h5);
    check({code_protect_en_o, prog_access_grant_o}, 2'b10);
    check(debugger_en_o, 1'b0);
    check(debug_pin_pair_o, 4'h8);
    check(pgm_guard_pages_o, 7'h01);
    rchk(16'hF200, 32'h00000003);
    check({scan_port_enable_o, cfg_reserved_err_o}, 2'h0);
    check(pgm_wr_allow_o, 1'b0);
    @(posedge clk_sys_i);
    pgm_wr_addr_i <= 18'h01000;
    #1;
    check(pgm_wr_allow_o, 1'b1);
  endtask

  task t_guard();
    load_word(32'hFE7BFFF5, 4'h2);
    check({boot_wr_allow_o, debugger_en_o}, 2'b01);
    check(pgm_guard_pages_o, 7'h40);
    check(debug_pin_pair_o, 4'h2);
    @(posedge clk_sys_i);
    pgm_wr_addr_i <= 18'h3F000;
    #1;
    check(pgm_wr_allow_o, 1'b0);
    pin_pulse(2'b01);
  endtask

  // Main sequence.
  initial begin
    t_open();
    t_regs();
    t_protect();
    t_guard();
    results();
  end
endmodule // boot_config_word_decode_test
